// file: pkg/wdr_consts.svh
`ifndef WDR_CONSTS_SVH
`define WDR_CONSTS_SVH

// Register offsets on the plain register port
`define WDR_OFF_WDC        8'h00
`define WDR_OFF_RCF        8'h04
`define WDR_OFF_RGK        8'h08
`define WDR_OFF_STAT       8'h0C
`define WDR_OFF_IRQ_ST     8'h10
`define WDR_OFF_IRQ_MASK   8'h14

// Reset values
`define WDR_WDC_POR        8'h53
`define WDR_RGK_POR        8'h55

// Watchdog control fields
`define WDR_KEY_MSB        7
`define WDR_KEY_LSB        3
`define WDR_SEL_MSB        2
`define WDR_SEL_LSB        0
`define WDR_KEY_A          5'h15
`define WDR_KEY_B          5'h0A

// Guard key no-action values
`define WDR_GUARD_A        8'h55
`define WDR_GUARD_B        8'hAA

// Reset cause flag positions
`define WDR_RCF_WD_BIT     0
`define WDR_RCF_GUARD_BIT  3

// Event bit positions in the interrupt registers
`define WDR_EV_TIMEOUT     0
`define WDR_EV_WD_KEY      1
`define WDR_EV_GUARD_KEY   2

// Timing: system clock, slow oscillator, invalid-key delay
`define WDR_CLK_HZ         20000000
`define WDR_SLOW_OSC_HZ    32000
`define WDR_SLOW_DIV       (`WDR_CLK_HZ / `WDR_SLOW_OSC_HZ)
`define WDR_KEY_DELAY      4

`endif

// file: pkg/wdr_pkg.sv
package wdr_pkg;

  // Register byte
  typedef logic [7:0] wdr_byte_t;

  // Watchdog counter
  typedef logic [17:0] wdr_cnt_t;

  // Invalid-key delay sequencer
  typedef enum logic [1:0] {
    WDR_G_IDLE = 2'b00,
    WDR_G_WAIT = 2'b01,
    WDR_G_FIRE = 2'b10
  } wdr_guard_e;

endpackage : wdr_pkg

// file: verilog/wdr_slow_tick.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"

module wdr_slow_tick #(
  parameter int DIV = `WDR_SLOW_DIV
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Slow oscillator enable pulse
  output logic      tick_q
);

  localparam int W = $clog2(DIV);

  logic [W-1:0] div_q;
  wire          div_last = (div_q == W'(DIV - 1));

  // Divide the system clock down to the slow oscillator rate
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_last ? '0 : div_q + W'(1);
      tick_q <= div_last;
    end
  end

endmodule : wdr_slow_tick

// file: verilog/wdr_key_guard.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"

module wdr_key_guard #(
  parameter int DELAY = `WDR_KEY_DELAY
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Slow oscillator enable and invalid key level
  input  wire logic tick,
  input  wire logic bad,
  // Reset request pulse after the delay
  output logic      fire_q
);

  localparam int W = $clog2(DELAY + 1);

  wdr_pkg::wdr_guard_e state_q;
  wdr_pkg::wdr_guard_e state_d;
  logic [W-1:0]        cnt_q;
  wire                 done = tick && (cnt_q == W'(DELAY - 1));

  // Next state: wait a fixed slow-clock count while the key stays bad
  always_comb begin
    state_d = state_q;
    case (state_q)
      wdr_pkg::WDR_G_IDLE: begin
        if (bad) state_d = wdr_pkg::WDR_G_WAIT;
      end
      wdr_pkg::WDR_G_WAIT: begin
        if (!bad) state_d = wdr_pkg::WDR_G_IDLE;
        else if (done) state_d = wdr_pkg::WDR_G_FIRE;
      end
      wdr_pkg::WDR_G_FIRE: begin
        state_d = wdr_pkg::WDR_G_IDLE;
      end
      default: begin
        state_d = wdr_pkg::WDR_G_IDLE;
      end
    endcase
  end

  // State, delay counter and output pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= wdr_pkg::WDR_G_IDLE;
      cnt_q   <= '0;
      fire_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q != wdr_pkg::WDR_G_WAIT) ? '0 : (tick ? cnt_q + W'(1) : cnt_q);
      fire_q  <= (state_q == wdr_pkg::WDR_G_WAIT) && bad && done;
    end
  end

  // Fire only after a bad key was seen
  a_fire_after_bad: assert property (@(posedge clk_sys) disable iff (reset)
    fire_q |-> $past(bad))
    else $error("guard fired without a bad key");

endmodule : wdr_key_guard

// file: verilog/wdr_top.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "wdr_consts.svh"

//Contract
// - Always-on option: both keys run, others reset
// - Register option: 10101 disables, 01010 enables
// - Bad key: delayed reset, set watchdog cause
// - Period select picks 2^8 to 2^18 ticks
// - Power-up watchdog control reads 0x53
// - Watchdog cause sticky, software zero clears
// - Cause register bits 7..4 read zero
// - Running overflow: full reset, set timeout
// - Halted overflow: timeout, PC/SP reset only
// - Counter clears on watchdog key reset, clear, halt
// - Guard key 0x55/0xAA idle, else reset
// - Power-up guard key reads 0x55
// - Guard cause sticky, software zero clears
// - Power-on reset zeroes program counter
// - Power-on reset presets port registers ones
// - Counter advances on slow oscillator ticks
// - Halt clears counter, resumes if enabled
module wdr_top #(
  parameter int SLOW_DIV  = `WDR_SLOW_DIV,
  parameter int KEY_DELAY = `WDR_KEY_DELAY
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_q,
  // Processor side
  input  wire logic       cfg_wdt_always_on,
  input  wire logic       clear_wdt_instr,
  input  wire logic       halt_instr,
  input  wire logic       cpu_halted,
  // Reset requests and status
  output logic            dev_reset_q,
  output logic            pc_sp_reset_q,
  output logic            timeout_status_flag_q,
  output logic            pc_clear_q,
  output logic            port_preset_q,
  // Interrupt
  output logic            irq_q
);

  // Terminal count of the watchdog counter for a period code
  function automatic wdr_pkg::wdr_cnt_t period_last(input logic [2:0] sel);
    logic [4:0] sh;
    sh = 5'd0;
    case (sel)
      3'd0:    sh = 5'd8;
      3'd1:    sh = 5'd10;
      3'd2:    sh = 5'd12;
      3'd3:    sh = 5'd14;
      3'd4:    sh = 5'd15;
      3'd5:    sh = 5'd16;
      3'd6:    sh = 5'd17;
      default: sh = 5'd18;
    endcase
    period_last = 18'((19'h0_0001 << sh) - 19'h0_0001);
  endfunction : period_last

  // Registers
  wdr_pkg::wdr_byte_t watchdog_control_q;
  wdr_pkg::wdr_byte_t reset_guard_key_q;
  logic               wd_key_reset_flag_q;
  logic               guard_key_reset_flag_q;
  logic [2:0]         irq_st_q;
  logic [2:0]         irq_mask_q;
  wdr_pkg::wdr_cnt_t  cnt_q;
  wdr_pkg::wdr_cnt_t  cnt_d;

  // Register write decode
  wire wr_wdc  = reg_wr && (reg_addr == `WDR_OFF_WDC);
  wire wr_rcf  = reg_wr && (reg_addr == `WDR_OFF_RCF);
  wire wr_rgk  = reg_wr && (reg_addr == `WDR_OFF_RGK);
  wire wr_ist  = reg_wr && (reg_addr == `WDR_OFF_IRQ_ST);
  wire wr_imsk = reg_wr && (reg_addr == `WDR_OFF_IRQ_MASK);

  // Key decode
  wire [4:0] enable_key_field    = watchdog_control_q[`WDR_KEY_MSB:`WDR_KEY_LSB];
  wire [2:0] period_select_field = watchdog_control_q[`WDR_SEL_MSB:`WDR_SEL_LSB];
  wire       key_a    = (enable_key_field == `WDR_KEY_A);
  wire       key_b    = (enable_key_field == `WDR_KEY_B);
  wire       key_ok   = key_a || key_b;
  wire       wd_on    = key_b || (key_a && cfg_wdt_always_on);
  wire       guard_ok = (reset_guard_key_q == `WDR_GUARD_A) || (reset_guard_key_q == `WDR_GUARD_B);

  // Slow oscillator enable and key guards
  logic slow_tick;
  logic wd_fire;
  logic guard_fire;

  wdr_slow_tick #(
    .DIV (SLOW_DIV)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick_q  (slow_tick)
  );

  wdr_key_guard #(
    .DELAY (KEY_DELAY)
  ) u_wd_guard (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (slow_tick),
    .bad     (!key_ok),
    .fire_q  (wd_fire)
  );

  wdr_key_guard #(
    .DELAY (KEY_DELAY)
  ) u_rg_guard (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (slow_tick),
    .bad     (!guard_ok),
    .fire_q  (guard_fire)
  );

  // Counter control
  wire                cnt_clr  = wd_fire || clear_wdt_instr || halt_instr;
  wire                cnt_step = wd_on && slow_tick;
  wdr_pkg::wdr_cnt_t  cnt_last;
  assign cnt_last = period_last(period_select_field);
  wire                at_last  = (cnt_q >= cnt_last); // Shortened period still ends at next tick
  wire                overflow = cnt_step && at_last && !cnt_clr;
  wire                any_dev_reset = (overflow && !cpu_halted) || wd_fire || guard_fire;

  // Next counter value
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_clr) cnt_d = '0;
    else if (cnt_step) cnt_d = at_last ? '0 : cnt_q + 18'h0_0001;
  end

  // Events for the interrupt status
  wire [2:0] ev_vec = {guard_fire, wd_fire, overflow};

  // Read data selection
  wire [7:0] rcf_val  = {4'h0, guard_key_reset_flag_q, 2'b00, wd_key_reset_flag_q};
  wire [7:0] stat_val = {4'h0, guard_ok, key_ok, wd_on, timeout_status_flag_q};
  wire [7:0] rd_mux   =
    (reg_addr == `WDR_OFF_WDC)      ? watchdog_control_q :
    (reg_addr == `WDR_OFF_RCF)      ? rcf_val :
    (reg_addr == `WDR_OFF_RGK)      ? reset_guard_key_q :
    (reg_addr == `WDR_OFF_STAT)     ? stat_val :
    (reg_addr == `WDR_OFF_IRQ_ST)   ? {5'h00, irq_st_q} :
    (reg_addr == `WDR_OFF_IRQ_MASK) ? {5'h00, irq_mask_q} : 8'h00;

  // Watchdog control and guard key registers; key resets restore defaults
  always_ff @(posedge clk_sys) begin
    if (reset || wd_fire) begin
      watchdog_control_q <= `WDR_WDC_POR;
    end else if (wr_wdc) begin
      watchdog_control_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || guard_fire) begin
      reset_guard_key_q <= `WDR_RGK_POR;
    end else if (wr_rgk) begin
      reset_guard_key_q <= reg_wdata;
    end
  end

  // Sticky cause flags: set wins over a software zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wd_key_reset_flag_q    <= 1'b0;
      guard_key_reset_flag_q <= 1'b0;
    end else begin
      wd_key_reset_flag_q    <= wd_fire ||
        (wd_key_reset_flag_q && !(wr_rcf && !reg_wdata[`WDR_RCF_WD_BIT]));
      guard_key_reset_flag_q <= guard_fire ||
        (guard_key_reset_flag_q && !(wr_rcf && !reg_wdata[`WDR_RCF_GUARD_BIT]));
    end
  end

  // Watchdog counter and timeout flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q                 <= '0;
      timeout_status_flag_q <= 1'b0;
    end else begin
      cnt_q                 <= cnt_d;
      timeout_status_flag_q <= overflow || (timeout_status_flag_q && !clear_wdt_instr && !halt_instr);
    end
  end

  // Reset request outputs and power-on presets
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dev_reset_q   <= 1'b0;
      pc_sp_reset_q <= 1'b0;
      pc_clear_q    <= 1'b1;
      port_preset_q <= 1'b1;
    end else begin
      dev_reset_q   <= any_dev_reset;
      pc_sp_reset_q <= overflow && cpu_halted;
      pc_clear_q    <= 1'b0;
      port_preset_q <= 1'b0;
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_st_q   <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_st_q   <= ev_vec | (irq_st_q & ~(wr_ist ? reg_wdata[2:0] : 3'h0));
      irq_mask_q <= wr_imsk ? reg_wdata[2:0] : irq_mask_q;
      irq_q      <= |(irq_st_q & irq_mask_q);
    end
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_wdc_por_value: assert property ($fell(reset) |-> watchdog_control_q == `WDR_WDC_POR)
    else $error("watchdog control not 0x53 after reset");

  a_guard_por_value: assert property ($fell(reset) |-> reset_guard_key_q == `WDR_RGK_POR)
    else $error("guard key not 0x55 after reset");

  a_wd_flag_set: assert property (wd_fire |=> wd_key_reset_flag_q && dev_reset_q)
    else $error("bad watchdog key did not reset and flag");

  a_wd_flag_sticky: assert property (wd_key_reset_flag_q && !wr_rcf |=> wd_key_reset_flag_q)
    else $error("watchdog cause flag dropped");

  a_guard_flag_sticky: assert property (guard_fire || (guard_key_reset_flag_q && !wr_rcf)
    |=> guard_key_reset_flag_q)
    else $error("guard cause flag not held");

  a_rcf_high_zero: assert property (reg_rd && reg_addr == `WDR_OFF_RCF |=> reg_rdata_q[7:4] == 4'h0)
    else $error("cause register upper bits not zero");

  a_run_overflow: assert property (overflow && !cpu_halted |=> dev_reset_q && timeout_status_flag_q)
    else $error("running overflow did not reset");

  a_halt_overflow: assert property (overflow && cpu_halted |=> pc_sp_reset_q && timeout_status_flag_q)
    else $error("halted overflow did not reset pc and sp");

  a_cnt_clear: assert property (clear_wdt_instr || halt_instr |=> cnt_q == 18'h0_0000)
    else $error("counter not cleared");

  a_cnt_hold_off: assert property (!wd_on && !cnt_clr |=> $stable(cnt_q))
    else $error("disabled counter moved");

  a_cnt_only_tick: assert property (!slow_tick && !cnt_clr |=> $stable(cnt_q))
    else $error("counter moved without slow tick");

  a_period_bound: assert property ($past(cnt_step) && !$past(wr_wdc) && !$past(wd_fire)
    |-> cnt_q <= cnt_last)
    else $error("counter beyond selected period");

endmodule : wdr_top

// file: verification/wdr_top_tb.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"

module wdr_top_tb;
  localparam int DIV = 4;
  localparam int KD  = 2;
  logic       clk_sys, reset, reg_wr, reg_rd, cfg, clr, hlt, halted;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic       dev_rst, pcsp_rst, to_flag, pc_clr, port_pre, irq;
  int         n_mismatch, compares;

  // Short counts so the three tested periods (codes 0 to 2) fit the run
  wdr_top #(.SLOW_DIV(DIV), .KEY_DELAY(KD)) uut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .cfg_wdt_always_on(cfg), .clear_wdt_instr(clr), .halt_instr(hlt), .cpu_halted(halted),
    .dev_reset_q(dev_rst), .pc_sp_reset_q(pcsp_rst), .timeout_status_flag_q(to_flag),
    .pc_clear_q(pc_clr), .port_preset_q(port_pre), .irq_q(irq));

  // Clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Clock cycles from clear to overflow for a period code
  function automatic int to_cycles(logic [2:0] code);
    int e[8] = '{8, 10, 12, 14, 15, 16, 17, 18};
    return (1 << e[code]) * DIV;
  endfunction : to_cycles

  // Random enable keys outside the two valid ones
  function automatic logic [4:0] bad_key();
    logic [4:0] k;
    do k = 5'($urandom); while (k == `WDR_KEY_A || k == `WDR_KEY_B);
    return k;
  endfunction : bad_key

  // Random guard bytes outside the two idle ones
  function automatic logic [7:0] bad_byte();
    logic [7:0] k;
    do k = 8'($urandom); while (k == `WDR_GUARD_A || k == `WDR_GUARD_B);
    return k;
  endfunction : bad_byte

  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic done(string nm);
    $display("Test %s finished", nm);
  endtask : done

  // Register port cycles
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata_q);
  endtask : rd

  // One-cycle clear or halt instruction
  task automatic instr(logic h);
    @(posedge clk_sys);
    hlt <= h;
    clr <= ~h;
    @(posedge clk_sys);
    hlt <= 1'b0;
    clr <= 1'b0;
  endtask : instr

  // Cycles until either reset pulse, zero if none within bound
  task automatic wait_rst(int bound, output int cyc, output logic dev);
    cyc = 0;
    dev = 1'b0;
    for (int i = 1; i <= bound; i++) begin
      @(posedge clk_sys);
      #1;
      if (dev_rst === 1'b1 || pcsp_rst === 1'b1) begin
        cyc = i;
        dev = dev_rst;
        break;
      end
    end
  endtask : wait_rst

  task automatic expect_rst(int lo, int hi, logic dev_exp, string nm);
    int   c;
    logic d;
    wait_rst(hi, c, d);
    if (c == 0) begin
      n_mismatch++;
      $display("MISMATCH %s expected 1 seen 0", nm);
      wrap_up();
    end else begin
      chk({nm, " delay"}, 8'h01, 8'(c >= lo));
      chk({nm, " source"}, {7'h0, dev_exp}, {7'h0, d});
    end
  endtask : expect_rst

  // Main sequence
  initial begin
    int   c;
    int   t;
    logic d;
    n_mismatch = 0;
    compares   = 0;
    {reset, reg_wr, reg_rd, cfg, clr, hlt, halted} = 7'h40;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    void'($urandom(49));
    repeat (9) @(posedge clk_sys);
    #1;
    chk("pc_clear", 8'h01, {7'h0, pc_clr});
    chk("port_preset", 8'h01, {7'h0, port_pre});
    @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pc_clear off", 8'h00, {7'h0, pc_clr});
    chk("port_preset off", 8'h00, {7'h0, port_pre});
    rd(`WDR_OFF_WDC, `WDR_WDC_POR, "wdc por");
    rd(`WDR_OFF_RGK, `WDR_RGK_POR, "guard por");
    rd(`WDR_OFF_RCF, 8'h00, "flags por");
    rd(8'h20, 8'h00, "unmapped");
    done("power-up");
    for (int s = 0; s < 3; s++) begin
      t = to_cycles(3'(s));
      wr(`WDR_OFF_WDC, {`WDR_KEY_B, 3'(s)});
      instr(1'b0);
      expect_rst(t - DIV, t + 4, 1'b1, "overflow");
      chk("timeout flag", 8'h01, {7'h0, to_flag});
      rd(`WDR_OFF_STAT, 8'h0F, "status");
      instr(1'b0);
      @(posedge clk_sys);
      #1;
      chk("flag cleared", 8'h00, {7'h0, to_flag});
    end
    done("periods");
    t = to_cycles(3'h0);
    @(posedge clk_sys);
    halted <= 1'b1;
    wr(`WDR_OFF_WDC, {`WDR_KEY_B, 3'h0});
    instr(1'b0);
    expect_rst(t - DIV, t + 4, 1'b0, "halted overflow");
    chk("halted flag", 8'h01, {7'h0, to_flag});
    instr(1'b1);
    @(posedge clk_sys);
    #1;
    chk("halt clears flag", 8'h00, {7'h0, to_flag});
    expect_rst(t - DIV - 2, t + 4, 1'b0, "after halt");
    @(posedge clk_sys);
    halted <= 1'b0;
    repeat (4) begin
      wait_rst(t - 4 * DIV, c, d);
      chk("cleared in time", 8'h00, 8'(c != 0));
      instr(1'b0);
    end
    done("halt and clear");
    wr(`WDR_OFF_WDC, {`WDR_KEY_A, 3'h0});
    instr(1'b0);
    wait_rst(2 * t, c, d);
    chk("disabled", 8'h00, 8'(c != 0));
    @(posedge clk_sys);
    cfg <= 1'b1;
    instr(1'b0);
    expect_rst(t - DIV, t + 4, 1'b1, "always on");
    @(posedge clk_sys);
    cfg <= 1'b0;
    wr(`WDR_OFF_WDC, `WDR_WDC_POR);
    done("enable keys");
    repeat (4) begin
      wr(`WDR_OFF_WDC, {bad_key(), 3'($urandom)});
      expect_rst((KD - 1) * DIV, (KD + 1) * DIV + 4, 1'b1, "bad key");
      rd(`WDR_OFF_WDC, `WDR_WDC_POR, "wdc restored");
      rd(`WDR_OFF_RCF, 8'h01, "wd flag");
      wr(`WDR_OFF_RCF, 8'hFF);
      rd(`WDR_OFF_RCF, 8'h01, "wd flag kept");
      wr(`WDR_OFF_RCF, 8'h00);
      rd(`WDR_OFF_RCF, 8'h00, "wd flag cleared");
    end
    repeat (4) begin
      wr(`WDR_OFF_RGK, bad_byte());
      expect_rst((KD - 1) * DIV, (KD + 1) * DIV + 4, 1'b1, "bad guard");
      rd(`WDR_OFF_RGK, `WDR_RGK_POR, "guard restored");
      rd(`WDR_OFF_RCF, 8'h08, "guard flag");
      wr(`WDR_OFF_RCF, 8'h00);
    end
    rd(`WDR_OFF_RCF, 8'h00, "guard flag cleared");
    wr(`WDR_OFF_RGK, `WDR_GUARD_B);
    wait_rst(4 * (KD + 1) * DIV, c, d);
    chk("guard idle", 8'h00, 8'(c != 0));
    rd(`WDR_OFF_RGK, `WDR_GUARD_B, "guard rw");
    wr(`WDR_OFF_RGK, `WDR_GUARD_A);
    done("bad keys");
    wr(`WDR_OFF_IRQ_ST, 8'h07);
    wr(`WDR_OFF_IRQ_MASK, 8'h00);
    wr(`WDR_OFF_WDC, 8'h00);
    expect_rst((KD - 1) * DIV, (KD + 1) * DIV + 4, 1'b1, "zero key");
    rd(`WDR_OFF_IRQ_ST, 8'h02, "irq status");
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(`WDR_OFF_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq raised", 8'h01, {7'h0, irq});
    wr(`WDR_OFF_IRQ_ST, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq cleared", 8'h00, {7'h0, irq});
    rd(`WDR_OFF_IRQ_MASK, 8'h02, "irq mask");
    done("interrupt");
    wrap_up();
  end
endmodule : wdr_top_tb
